// ### hdl/serial_framer_defines.svh
// Constants of the seven-unit character framer: register map, fields,
// reset values, codes and timing.
// Assumes a 10 MHz mclk and a 32-bit AXI4-Lite register bus.
`ifndef SERIAL_FRAMER_DEFINES_SVH
`define SERIAL_FRAMER_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_TXDATA 8'h08
`define OFS_RXDATA 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

// Control fields
`define CTRL_SYNC 0
`define CTRL_TWO_STOP 1
`define CTRL_PAR_INV 2
`define CTRL_SUB_EN 3
`define CTRL_RATE_LSB 4
`define CTRL_RATE_MSB 6
`define CTRL_RESET 32'h0000_0000

// Status fields
`define STAT_TX_BUSY 0
`define STAT_TX_PEND 1
`define STAT_RX_FULL 2
`define STAT_RX_HUNT 3

// Received data fields
`define RXD_ERR 7

// Interrupt bits
`define IRQ_TX_DONE 0
`define IRQ_RX_CHAR 1
`define IRQ_RX_PAR 2
`define IRQ_RX_FRAME 3
`define IRQ_RX_OVR 4
`define IRQ_N 5
`define IRQ_RESET 5'h00

// Control codes of the alphabet
`define SUB_CODE 7'h1a
`define SYNC_CODE 7'h16

// Timing: clock rate, oversampling and selectable rates
`define MCLK_HZ 25'h098_9680
`define OS_LOG2 4
`define BAUD_600 25'h000_0258
`define BAUD_1200 25'h000_04b0
`define BAUD_2400 25'h000_0960
`define BAUD_4800 25'h000_12c0
`define BAUD_9600 25'h000_2580
`define BAUD_200 25'h000_00c8
`define BAUD_300 25'h000_012c

`endif

// ### hdl/serial_framer_pkg.sv
// Types and shared decoding of the seven-unit character framer.
// Assumes nothing beyond the defines header for constants.
package serial_framer_pkg;

   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP}
      tx_state_type;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP,
      RX_HUNT, RX_SYNC} rx_state_type;

   // Parity bit for seven data bits; odd selects odd sense
   function automatic logic parity_of(input logic [6:0] d,
                                      input logic odd);
      parity_of = (^d) ^ odd;
   endfunction : parity_of

endpackage : serial_framer_pkg

// ### hdl/rate_divider.sv
// Fractional divider giving sixteen-times and unit-interval enables.
// Assumes mclk at the rate in the defines header; one clock domain.
`timescale 1ns/10ps
`include "serial_framer_defines.svh"
module rate_divider
   import serial_framer_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [2:0] rate_sel,
   output logic os_tick,
   output logic ui_tick
);

   logic [24:0] acc;
   logic [24:0] inc;
   logic [24:0] sum;
   logic [3:0] os_cnt;

   // Rate code to baud
   function automatic logic [24:0] baud_of(input logic [2:0] sel);
      case (sel)
         3'h0: baud_of = `BAUD_600;
         3'h1: baud_of = `BAUD_1200;
         3'h2: baud_of = `BAUD_2400;
         3'h3: baud_of = `BAUD_4800;
         3'h4: baud_of = `BAUD_9600;
         3'h5: baud_of = `BAUD_200;
         default: baud_of = `BAUD_300;
      endcase
   endfunction : baud_of

   // Step is sixteen times the rate per clock
   assign inc = baud_of(rate_sel) << `OS_LOG2;
   assign sum = acc + inc;

   // Phase accumulator: exact average rate, one clock of jitter
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         acc <= 25'h000_0000;
         os_tick <= 1'b0;
      end else if (sum >= `MCLK_HZ) begin
         acc <= sum - `MCLK_HZ;
         os_tick <= 1'b1;
      end else begin
         acc <= sum;
         os_tick <= 1'b0;
      end
   end

   // Unit interval is sixteen oversample ticks
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         os_cnt <= 4'h0;
         ui_tick <= 1'b0;
      end else begin
         ui_tick <= os_tick && (os_cnt == 4'hf);
         if (os_tick) begin
            os_cnt <= os_cnt + 4'h1;
         end
      end
   end

endmodule : rate_divider

// ### hdl/char_receiver.sv
// Receive deframer: start-stop or character-synchronous, 16x sampling.
// Assumes line_rx is asynchronous to mclk; os_tick from rate_divider.
`timescale 1ns/10ps
`include "serial_framer_defines.svh"
module char_receiver
   import serial_framer_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic line_rx,
   input wire logic os_tick,
   input wire logic sync_mode,
   input wire logic odd_sel,
   output logic rx_done,
   output logic [7:0] rx_char,
   output logic frame_err,
   output logic hunting
);

   rx_state_type state;
   logic s1, s2, s3;
   logic line_q, line_prev, mode_q;
   logic [3:0] ph;
   logic [2:0] bitn;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic mid;

   // Three-stage synchroniser; only stages two and three are compared
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         line_q <= 1'b1;
         line_prev <= 1'b1;
      end else begin
         s1 <= line_rx;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            line_q <= s3;
         end
         line_prev <= line_q;
      end
   end

   assign next_shift = {line_q, shift[7:1]};
   // Start-stop samples at mid start plus whole bits; sync at mid bit
   assign mid = sync_mode ? (ph == 4'h7) : (ph == 4'hf);
   assign hunting = (state == RX_HUNT);

   // Framing state machine
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state <= RX_IDLE;
         ph <= 4'h0;
         bitn <= 3'h0;
         shift <= 8'hff;
         mode_q <= 1'b0;
         rx_done <= 1'b0;
         rx_char <= 8'h00;
         frame_err <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         frame_err <= 1'b0;
         mode_q <= sync_mode;
         if (sync_mode && line_q != line_prev) begin
            ph <= 4'h0; // Sync mode follows line transitions
         end else if (os_tick) begin
            ph <= ph + 4'h1;
         end
         if (mode_q != sync_mode) begin
            state <= sync_mode ? RX_HUNT : RX_IDLE;
         end else begin
            case (state)
               RX_IDLE: begin
                  if (!line_q) begin
                     state <= RX_START;
                     ph <= 4'h0;
                  end
               end
               RX_START: begin
                  if (os_tick && ph == 4'h7) begin
                     ph <= 4'h0;
                     bitn <= 3'h0;
                     state <= line_q ? RX_IDLE : RX_DATA; // Glitch reject
                  end
               end
               RX_DATA: begin
                  if (os_tick && mid) begin
                     shift <= next_shift;
                     bitn <= bitn + 3'h1;
                     if (bitn == 3'h7) begin
                        state <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  // Judged at mid stop: shortened or single stops pass
                  if (os_tick && mid && bitn == 3'h0) begin
                     rx_done <= line_q;
                     frame_err <= !line_q;
                     rx_char <= shift;
                     bitn <= 3'h1; // Broken frame is dropped, not retried
                     state <= line_q ? RX_IDLE : RX_STOP;
                  end else if (line_q && bitn != 3'h0) begin
                     state <= RX_IDLE; // Mark again after a framing error
                  end
               end
               RX_HUNT: begin
                  if (os_tick && mid) begin
                     shift <= next_shift;
                     if (next_shift == {parity_of(`SYNC_CODE, odd_sel),
                                        `SYNC_CODE}) begin
                        bitn <= 3'h0;
                        state <= RX_SYNC;
                     end
                  end
               end
               RX_SYNC: begin
                  if (os_tick && mid) begin
                     shift <= next_shift;
                     bitn <= bitn + 3'h1;
                     if (bitn == 3'h7) begin
                        rx_done <= 1'b1;
                        rx_char <= next_shift;
                     end
                  end
               end
               default: state <= RX_IDLE;
            endcase
         end
      end
   end

endmodule : char_receiver

// ### hdl/serial_framer.sv
// Seven-unit character framer with AXI4-Lite registers and interrupt.
// Assumes one 10 MHz clock, synchronous active-low reset, and a serial
// line pair whose receive side is asynchronous to mclk.
`timescale 1ns/10ps
`include "serial_framer_defines.svh"
module serial_framer
   import serial_framer_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic line_tx,
   input wire logic line_rx,
   output logic irq
);

   // Bus capture
   logic [7:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic wr_go;
   logic rd_go;

   // Control fields
   logic sync_mode;
   logic two_stop;
   logic par_inv;
   logic sub_en;
   logic [2:0] rate_sel;
   logic odd_sel;
   // A literal cannot be bit-selected, so the reset word is held here
   localparam logic [31:0] ctrl_init = `CTRL_RESET;

   // Transmit path
   tx_state_type tx_state;
   logic [6:0] tx_hold;
   logic tx_pend;
   logic [7:0] tx_shift;
   logic [2:0] tx_cnt;
   logic tx_stop_left;
   logic tx_done;
   logic tx_take;

   // Receive path
   logic rx_done;
   logic [7:0] rx_char;
   logic frame_err;
   logic hunting;
   logic rx_bad;
   logic [7:0] rx_data;
   logic rx_full;
   logic rx_read;

   // Interrupts
   logic [`IRQ_N-1:0] irq_status;
   logic [`IRQ_N-1:0] irq_mask;
   logic [`IRQ_N-1:0] irq_event;
   logic [`IRQ_N-1:0] irq_clear;

   logic os_tick;
   logic ui_tick;

   // Address decode, shared by both bus directions
   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         `OFS_CTRL, `OFS_STATUS, `OFS_TXDATA, `OFS_RXDATA,
         `OFS_IRQ_STATUS, `OFS_IRQ_MASK: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   rate_divider u_rate (
      .mclk(mclk),
      .nrst(nrst),
      .rate_sel(rate_sel),
      .os_tick(os_tick),
      .ui_tick(ui_tick)
   );

   char_receiver u_rx (
      .mclk(mclk),
      .nrst(nrst),
      .line_rx(line_rx),
      .os_tick(os_tick),
      .sync_mode(sync_mode),
      .odd_sel(odd_sel),
      .rx_done(rx_done),
      .rx_char(rx_char),
      .frame_err(frame_err),
      .hunting(hunting)
   );

   // Parity sense: even start-stop, odd synchronous, optionally inverted
   assign odd_sel = sync_mode ^ par_inv;

   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   // Write address and data taken independently, in either order
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer with a decode error
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= is_mapped(aw_addr) ? 2'h0 : 2'h3;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register; only byte lane zero carries fields
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sync_mode <= ctrl_init[`CTRL_SYNC];
         two_stop <= ctrl_init[`CTRL_TWO_STOP];
         par_inv <= ctrl_init[`CTRL_PAR_INV];
         sub_en <= ctrl_init[`CTRL_SUB_EN];
         rate_sel <= ctrl_init[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
      end else if (wr_go && aw_addr == `OFS_CTRL && w_strb[0]) begin
         sync_mode <= w_data[`CTRL_SYNC];
         two_stop <= w_data[`CTRL_TWO_STOP];
         par_inv <= w_data[`CTRL_PAR_INV];
         sub_en <= w_data[`CTRL_SUB_EN];
         rate_sel <= w_data[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
      end
   end

   // Transmit holding word; a write while one waits is dropped
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tx_hold <= 7'h00;
         tx_pend <= 1'b0;
      end else if (wr_go && aw_addr == `OFS_TXDATA && w_strb[0] &&
                   !tx_pend) begin
         tx_hold <= w_data[6:0];
         tx_pend <= 1'b1;
      end else if (tx_take) begin
         tx_pend <= 1'b0;
      end
   end

   // Character boundary where the next one may begin
   assign tx_take = ui_tick && tx_pend &&
      (tx_state == TX_IDLE ||
       (tx_state == TX_STOP && !tx_stop_left) ||
       (tx_state == TX_DATA && tx_cnt == 3'h7 && sync_mode));

   // Transmit sequencer, one step per unit interval
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tx_state <= TX_IDLE;
         tx_shift <= 8'hff;
         tx_cnt <= 3'h0;
         tx_stop_left <= 1'b0;
         tx_done <= 1'b0;
         line_tx <= 1'b1;
      end else begin
         tx_done <= 1'b0;
         if (tx_take) begin
            tx_shift <= {parity_of(tx_hold, odd_sel), tx_hold};
            if (sync_mode) begin
               // No start element; first data bit goes at once
               tx_state <= TX_DATA;
               tx_cnt <= 3'h0;
               line_tx <= tx_hold[0];
               tx_shift <= {1'b1, parity_of(tx_hold, odd_sel),
                            tx_hold[6:1]};
            end else begin
               tx_state <= TX_START;
               line_tx <= 1'b0;
            end
            if (tx_state != TX_IDLE) begin
               tx_done <= 1'b1;
            end
         end else if (ui_tick) begin
            case (tx_state)
               TX_IDLE: line_tx <= 1'b1;
               TX_START: begin
                  tx_state <= TX_DATA;
                  tx_cnt <= 3'h0;
                  line_tx <= tx_shift[0];
                  tx_shift <= {1'b1, tx_shift[7:1]};
               end
               TX_DATA: begin
                  if (tx_cnt == 3'h7) begin
                     line_tx <= 1'b1;
                     if (sync_mode) begin
                        tx_state <= TX_IDLE;
                        tx_done <= 1'b1;
                     end else begin
                        tx_state <= TX_STOP;
                        tx_stop_left <= two_stop;
                     end
                  end else begin
                     tx_cnt <= tx_cnt + 3'h1;
                     line_tx <= tx_shift[0];
                     tx_shift <= {1'b1, tx_shift[7:1]};
                  end
               end
               TX_STOP: begin
                  if (tx_stop_left) begin
                     tx_stop_left <= 1'b0;
                  end else begin
                     tx_state <= TX_IDLE;
                     tx_done <= 1'b1;
                  end
               end
               default: tx_state <= TX_IDLE;
            endcase
         end
      end
   end

   // Wrong parity or a received SUB are one and the same error
   assign rx_bad = (rx_char[7] != parity_of(rx_char[6:0], odd_sel)) ||
                   (rx_char[6:0] == `SUB_CODE);
   assign rx_read = rd_go && s_axi_araddr == `OFS_RXDATA;

   // Receive holding word, emptied by reading it
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rx_data <= 8'h00;
         rx_full <= 1'b0;
      end else if (rx_done) begin
         // Substitution keeps the error flag, so it is never silent
         rx_data <= {rx_bad, (rx_bad && sub_en) ? `SUB_CODE
                                                : rx_char[6:0]};
         rx_full <= 1'b1;
      end else if (rx_read) begin
         rx_full <= 1'b0;
      end
   end

   assign irq_event[`IRQ_TX_DONE] = tx_done;
   assign irq_event[`IRQ_RX_CHAR] = rx_done;
   assign irq_event[`IRQ_RX_PAR] = rx_done && rx_bad;
   assign irq_event[`IRQ_RX_FRAME] = frame_err;
   assign irq_event[`IRQ_RX_OVR] = rx_done && rx_full && !rx_read;
   assign irq_clear = (wr_go && aw_addr == `OFS_IRQ_STATUS && w_strb[0])
                      ? w_data[`IRQ_N-1:0] : `IRQ_RESET;

   // Sticky event bits; a new event beats a clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_N; gi = gi + 1) begin : g_irq
         always_ff @(posedge mclk) begin
            if (!nrst) begin
               irq_status[gi] <= 1'b0;
            end else if (irq_event[gi]) begin
               irq_status[gi] <= 1'b1;
            end else if (irq_clear[gi]) begin
               irq_status[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Interrupt mask register
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         irq_mask <= `IRQ_RESET;
      end else if (wr_go && aw_addr == `OFS_IRQ_MASK && w_strb[0]) begin
         irq_mask <= w_data[`IRQ_N-1:0];
      end
   end

   // Registered interrupt level
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // Read channel: one read at a time, data one cycle after address
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h3;
            s_axi_rdata <= 32'h0000_0000;
            case (s_axi_araddr)
               `OFS_CTRL: begin
                  s_axi_rdata[`CTRL_SYNC] <= sync_mode;
                  s_axi_rdata[`CTRL_TWO_STOP] <= two_stop;
                  s_axi_rdata[`CTRL_PAR_INV] <= par_inv;
                  s_axi_rdata[`CTRL_SUB_EN] <= sub_en;
                  s_axi_rdata[`CTRL_RATE_MSB:`CTRL_RATE_LSB] <= rate_sel;
               end
               `OFS_STATUS: begin
                  s_axi_rdata[`STAT_TX_BUSY] <= (tx_state != TX_IDLE);
                  s_axi_rdata[`STAT_TX_PEND] <= tx_pend;
                  s_axi_rdata[`STAT_RX_FULL] <= rx_full;
                  s_axi_rdata[`STAT_RX_HUNT] <= hunting;
               end
               `OFS_TXDATA: s_axi_rdata[6:0] <= tx_hold;
               `OFS_RXDATA: s_axi_rdata[7:0] <= rx_data;
               `OFS_IRQ_STATUS: s_axi_rdata[`IRQ_N-1:0] <= irq_status;
               `OFS_IRQ_MASK: s_axi_rdata[`IRQ_N-1:0] <= irq_mask;
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : serial_framer

// ### bench/framer_properties.sv
// Port checks of the framer: bus handshakes and line idle/start.
// Assumes binding onto serial_framer; one clock domain.
`timescale 1ns/10ps
module framer_properties (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic line_tx
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Responses stand until taken
   property p_bhold;
      s_axi_bvalid && !s_axi_bready
         |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("bresp dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready
         |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("rdata dropped");
   // Answer latencies from the hand-over
   property p_rlat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read late");
   property p_blat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_blat: assert property (p_blat) else $error("write late");
   // No second request while one is held
   property p_arref;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_arref: assert property (p_arref) else $error("arready early");
   property p_awtog;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   a_awtog: assert property (p_awtog) else $error("awready held");
   // Unmapped read decodes as error with zero data
   property p_unmap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18
         |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   // A start element is never a glitch
   property p_start;
      $fell(line_tx) |-> !line_tx [*8];
   endproperty
   a_start: assert property (p_start) else $error("short start");
   property p_rst;
      $rose(nrst) |-> line_tx;
   endproperty
   a_rst: assert property (p_rst) else $error("line not mark");
endmodule : framer_properties

// ### bench/line_peer.sv
// Remote terminal: start-stop sender and frame catcher on the line.
// Assumes 9600 bit/s from a 10 MHz mclk, so about 1042 clocks a unit.
`timescale 1ns/10ps
module line_peer #(parameter int UI = 1042) (
   input wire logic mclk,
   input wire logic line_tx,
   output logic line_rx
);
   logic [8:0] got;
   initial line_rx = 1'h1;
   // Mid-unit sampling; nine samples take data, parity and stop
   always begin
      @(negedge line_tx);
      repeat (UI / 2) @(posedge mclk);
      repeat (9) begin
         repeat (UI) @(posedge mclk);
         got = {line_tx, got[8:1]};
      end
   end
   // One-unit stop only, so a two-stop receiver is stressed
   task send(input logic [7:0] f);
      logic [9:0] w;
      w = {1'h1, f, 1'h0};
      repeat (10) begin
         @(posedge mclk);
         line_rx <= w[0];
         w = {1'h1, w[9:1]};
         repeat (UI - 1) @(posedge mclk);
      end
   endtask : send
endmodule : line_peer

// ### bench/testbench.sv
// Self-checking bench of the framer: registers, interrupt, both paths.
// Assumes the line peer at 9600 bit/s and the design defines header.
`timescale 1ns/10ps
`include "serial_framer_defines.svh"
module testbench;
   logic mclk, nrst = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, rd_d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, line_tx, line_rx, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
   logic [31:0] s_axi_rdata, seed = 32'h3999_0fd0;
   logic [6:0] a;
   integer error_cnt = 0, checks_done = 0, k;
   serial_framer serial_framer_inst (.*);
   line_peer line_peer_inst (.mclk(mclk), .line_tx(line_tx),
      .line_rx(line_rx));
   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end
   function logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task test_done;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   task tmo;
      error_cnt++;
      test_done;
   endtask : tmo
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // Bus write; response kept in rd_r
   task wr(input logic [7:0] ad, input logic [31:0] d);
      integer i;
      @(posedge mclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (i = 0; i < 60; i++) begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      rd_r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      if (i == 60) tmo;
   endtask : wr
   task rd(input logic [7:0] ad);
      integer i;
      @(posedge mclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (i = 0; i < 60; i++) begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (i == 60) tmo;
   endtask : rd
   // Main sequence; every wait is bounded
   initial begin
      repeat (20) @(posedge mclk);
      nrst <= 1'h1;
      repeat (2) @(posedge mclk);
      rd(`OFS_CTRL);
      chk("ctrl", 32'h0000_0000, rd_d);
      rd(`OFS_IRQ_MASK);
      chk("mask", 32'h0000_0000, rd_d);
      rd(8'h18);
      chk("rresp", 32'h0000_0003, rd_r);
      wr(8'h1c, 32'h0000_0001);
      chk("bresp", 32'h0000_0003, rd_r);
      wr(`OFS_IRQ_MASK, 32'h0000_001f);
      // Transmit with plain then inverted parity sense
      for (k = 0; k < 2; k++) begin
         seed = lfsr(seed);
         wr(`OFS_CTRL, k ? 32'h0000_0044 : 32'h0000_0040);
         wr(`OFS_TXDATA, {25'h0, seed[6:0]});
         for (int i = 0; i < 12000 && irq !== 1'h1; i++) @(posedge mclk);
         if (irq !== 1'h1) tmo;
         chk("txframe", {1'h1, ^seed[6:0] ^ k[0], seed[6:0]},
            line_peer_inst.got);
         rd(`OFS_IRQ_STATUS);
         chk("txdone", 32'h0000_0001, rd_d & 32'h0000_0001);
         wr(`OFS_IRQ_STATUS, 32'h0000_001f);
         repeat (2) @(posedge mclk);
         chk("irqclr", 32'h0000_0000, irq);
      end
      // Two-stop receiver fed single stops back to back
      wr(`OFS_CTRL, 32'h0000_004a);
      seed = lfsr(seed);
      a = seed[6:0] | 7'h40;
      line_peer_inst.send({^a, a});
      fork
         line_peer_inst.send({~^seed[14:8], seed[14:8]});
         begin
            rd(`OFS_RXDATA);
            chk("rxgood", {24'h0, 1'h0, a}, rd_d);
         end
      join
      rd(`OFS_RXDATA);
      chk("rxbad", 32'h0000_009a, rd_d);
      rd(`OFS_IRQ_STATUS);
      chk("parirq", 32'h0000_0004, rd_d & 32'h0000_0004);
      line_peer_inst.send({^7'h1a, 7'h1a});
      rd(`OFS_RXDATA);
      chk("rxsub", 32'h0000_009a, rd_d);
      chk("irqon", 32'h0000_0001, irq);
      wr(`OFS_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      chk("irqmask", 32'h0000_0000, irq);
      test_done;
   end
endmodule : testbench
bind serial_framer framer_properties framer_properties_inst (.*);
